// ### logic/word_storage_unit.sv
// Word storage unit with calendar time records
`include "word_store_params.svh"
`default_nettype none
// Function
// - Count up once per stored word
// - Count down once per word read
// - Time record is six 10-bit words
// - Time record header word equals seven
// - Then year, month, day, hour, minute
// - Time record with first record after power
// - Daily time record after midnight
// - Calendar handles month lengths and leap years
// - Capacity is 65520 words total
// - Full store drains and drops further words
// - First six-word record after power-on gives count of twelve
module word_storage_unit import word_store_pkg::*; #(
   parameter longint MINUTE_CYC = `WS_MINUTE_CYC,
   parameter int     DEPTH      = 65536
) (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        IN_VALID,
   output logic             IN_READY,
   input  wire logic [9:0]  IN_WORD,
   input  wire logic        IN_REC_END,
   input  wire logic        RD_REQ,
   output logic             RD_VALID,
   output logic      [9:0]  RD_WORD,
   output logic      [16:0] WORD_COUNT,
   output logic             FULL
);
   // ****************************************
   // Input FIFO
   // ****************************************
   logic        f_valid;                // FIFO has a word
   logic [9:0]  f_data;                 // FIFO head word
   logic        f_ready;                // Drain accepts head
   logic        f_in_ready;             // FIFO space
   logic        f_push;                 // Word offered to the FIFO
   logic        in_ready_r;             // Registered FIFO space

   // Offer a word only while the registered ready is shown; the FIFO still refuses it in the cycle after it fills
   assign f_push = IN_VALID && in_ready_r;

   // Sixteen-word buffer between the sender and the store
   word_fifo #(
      .WIDTH (`WS_WORD_W),
      .DEPTH (`WS_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .reset     (RESET),
      .in_valid  (f_push),
      .in_ready  (f_in_ready),
      .in_data   (IN_WORD),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // Ready is registered; it is low until the first edge after reset
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         in_ready_r <= 1'b0;
      end else begin
         in_ready_r <= f_in_ready;
      end
   end

   // ****************************************
   // Calendar clock
   // ****************************************
   // Prescaler is wide so that a full minute of system clock fits
   logic [63:0] tick_r;                 // Minute prescaler
   logic [5:0]  minute_r;               // Minute 0..59
   logic [4:0]  hour_r;                 // Hour 0..23
   logic [4:0]  day_r;                  // Day 1..31
   logic [3:0]  month_r;                // Month 1..12
   logic [6:0]  year_r;                 // Year 0..99
   logic        day_flag_r;             // Time record pending

   // Carry chain: each field wraps only when all lower fields wrap
   wire         min_tick  = (tick_r == 64'(MINUTE_CYC - 1));
   wire         hour_wrap = min_tick && (minute_r == 6'd59);
   wire         day_wrap  = hour_wrap && (hour_r == 5'd23);
   // Two-digit year; every fourth year is a leap year
   wire         leap      = (year_r[1:0] == 2'b00);
   // Days in the current month
   wire [4:0]   mdays     = (month_r == 4'd2) ? (leap ? 5'd29 : 5'd28) :
                            ((month_r == 4'd4) || (month_r == 4'd6) ||
                             (month_r == 4'd9) || (month_r == 4'd11)) ? 5'd30 : 5'd31;
   wire         mon_wrap  = day_wrap && (day_r == mdays);
   wire         yr_wrap   = mon_wrap && (month_r == 4'd12);

   // Time of day and date advance; no correction from outside is needed
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         tick_r   <= '0;
         minute_r <= '0;
         hour_r   <= '0;
         day_r    <= `WS_RESET_DAY;
         month_r  <= `WS_RESET_MONTH;
         year_r   <= `WS_RESET_YEAR;
      end else begin
         tick_r <= min_tick ? '0 : tick_r + 64'd1;
         if (min_tick) minute_r <= hour_wrap ? '0 : minute_r + 6'd1;
         if (hour_wrap) hour_r <= day_wrap ? '0 : hour_r + 5'd1;
         if (day_wrap) day_r <= mon_wrap ? 5'd1 : day_r + 5'd1;
         if (mon_wrap) month_r <= yr_wrap ? 4'd1 : month_r + 4'd1;
         if (yr_wrap) year_r <= (year_r == 7'd99) ? '0 : year_r + 7'd1;
      end
   end
   // ****************************************
   // Store sequencer
   // ****************************************
   store_state_e state_r;               // Sequencer state
   logic [2:0]   idx_r;                 // Word index in record
   logic         end_pend_r;            // Record end seen, words still buffered
   logic [16:0]  count_r;               // Words held
   logic         full_r;                // Registered full flag
   logic [15:0]  wr_ptr_r;              // Next write address
   logic [15:0]  rd_ptr_r;              // Next read address
   logic [9:0]   mem [DEPTH];           // Non-volatile store
   logic         rd_valid_r;            // Read word valid
   logic [9:0]   rd_word_r;             // Read word

   // Capacity checks on the live count
   wire          full      = (count_r >= `WS_CAPACITY);
   wire          room6     = (count_r <= `WS_CAPACITY - 17'd6);
   wire          need_time = day_flag_r;

   // Time record word selected by its index
   wire [9:0]    time_word = (idx_r == 3'd0) ? `WS_TIME_HEADER :
                             (idx_r == 3'd1) ? 10'(year_r) :
                             (idx_r == 3'd2) ? 10'(month_r) :
                             (idx_r == 3'd3) ? 10'(day_r) :
                             (idx_r == 3'd4) ? 10'(hour_r) : 10'(minute_r);

   // Record start decisions, taken only in idle with a word waiting
   wire          start_time = (state_r == ST_IDLE) && f_valid && need_time && room6;
   wire          skip_time  = (state_r == ST_IDLE) && f_valid && need_time && !room6;
   wire          last_time  = (state_r == ST_TIME) && (idx_r == `WS_REC_WORDS - 3'd1);
   wire          rec_end    = IN_REC_END || end_pend_r;

   // Write and read selection; writes take priority over reads
   wire          do_time   = (state_r == ST_TIME);
   wire          do_drain  = (state_r != ST_TIME) && f_valid && !start_time;
   wire          do_meas   = do_drain && !full;
   wire          do_write  = do_time || do_meas;
   wire          do_read   = RD_REQ && (count_r != '0) && !do_write;
   wire [9:0]    wr_data   = do_time ? time_word : f_data;

   // Next count: up on a write, down on a read
   wire [16:0]   count_up   = count_r + 17'd1;
   wire [16:0]   count_down = count_r - 17'd1;
   wire [16:0]   count_nxt  = do_write ? count_up : (do_read ? count_down : count_r);

   // The head word is held back while a time record goes in front of it;
   // a full store still drains words so the sender is never stalled
   assign f_ready = (state_r != ST_TIME) && !start_time;

   // Sequencer: time record precedes the first measurement word
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_r    <= ST_IDLE;
         idx_r      <= '0;
         end_pend_r <= 1'b0;
         day_flag_r <= 1'b1;           // Power-on time record pending
      end else begin
         // A midnight always re-arms the time record
         if (day_wrap) day_flag_r <= 1'b1;
         unique case (state_r)
            // Waiting for the first word of a record
            ST_IDLE: begin
               if (start_time) begin
                  state_r <= ST_TIME;
                  idx_r   <= '0;
               end else if (f_valid) begin
                  state_r <= ST_MEAS;
                  // No room for six words: the record is dropped whole
                  if (skip_time && !day_wrap) day_flag_r <= 1'b0;
               end
            end
            // Six time words; a record end may arrive meanwhile
            ST_TIME: begin
               idx_r <= idx_r + 3'd1;
               if (IN_REC_END) end_pend_r <= 1'b1;
               if (last_time) begin
                  state_r <= ST_MEAS;
                  if (!day_wrap) day_flag_r <= 1'b0;
               end
            end
            // Measurement words; idle again once the record end and its words are through
            ST_MEAS: begin
               if (rec_end && !f_valid) begin
                  state_r    <= ST_IDLE;
                  end_pend_r <= 1'b0;
               end else if (IN_REC_END) begin
                  end_pend_r <= 1'b1;
               end
            end
         endcase
      end
   end

   // Count, full flag and pointers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         count_r    <= '0;
         full_r     <= 1'b0;
         wr_ptr_r   <= '0;
         rd_ptr_r   <= '0;
         rd_valid_r <= 1'b0;
         rd_word_r  <= '0;
      end else begin
         rd_valid_r <= do_read;
         count_r    <= count_nxt;
         full_r     <= (count_nxt >= `WS_CAPACITY);
         // Write side
         if (do_write) begin
            wr_ptr_r <= wr_ptr_r + 16'd1;
         end
         // Read side
         if (do_read) begin
            rd_ptr_r  <= rd_ptr_r + 16'd1;
            rd_word_r <= mem[rd_ptr_r];
         end
      end
   end

   // Store write; a full store leaves its contents unchanged
   always_ff @(posedge CLK) begin
      if (do_write) mem[wr_ptr_r] <= wr_data;
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output is a flip-flop
   assign IN_READY   = in_ready_r;
   assign RD_VALID   = rd_valid_r;
   assign RD_WORD    = rd_word_r;
   assign WORD_COUNT = count_r;
   assign FULL       = full_r;

   // ****************************************
   // Assertions
   // ****************************************
   // Count never climbs past capacity
   a_count_full: assert property (@(posedge CLK) disable iff (RESET)
      full |=> !$rose(count_r > `WS_CAPACITY)) else $error("count beyond capacity");
   a_header_seven: assert property (@(posedge CLK) disable iff (RESET)
      (do_time && idx_r == 3'd0) |-> wr_data == 10'h007) else $error("bad header");
   a_count_up: assert property (@(posedge CLK) disable iff (RESET)
      do_write |=> count_r == $past(count_r) + 17'd1) else $error("count not up");
   a_count_down: assert property (@(posedge CLK) disable iff (RESET)
      do_read |=> count_r == $past(count_r) - 17'd1) else $error("count not down");
   a_time_six: assert property (@(posedge CLK) disable iff (RESET)
      $rose(do_time) |-> do_time [*6] ##1 !do_time) else $error("record not six");
   a_cap_limit: assert property (@(posedge CLK) disable iff (RESET)
      count_r <= `WS_CAPACITY) else $error("over capacity");
   a_day_wrap: assert property (@(posedge CLK) disable iff (RESET)
      mon_wrap |=> day_r == 5'd1) else $error("day wrap");
   a_daily_flag: assert property (@(posedge CLK) disable iff (RESET)
      day_wrap |=> day_flag_r) else $error("daily flag missing");
   // Full store writes nothing
   a_refuse_full: assert property (@(posedge CLK) disable iff (RESET)
      full |-> !do_write) else $error("write while full");
   // Full flag follows the count
   a_full_flag: assert property (@(posedge CLK) disable iff (RESET)
      full_r == (count_r >= 17'd65520)) else $error("full flag wrong");
   // A time record starts only with room for all six words
   a_time_room: assert property (@(posedge CLK) disable iff (RESET)
      $rose(do_time) |-> $past(count_r) <= 17'd65514) else $error("time record without room");
   // Pending time record with room starts on the next edge
   a_time_start: assert property (@(posedge CLK) disable iff (RESET)
      (state_r == ST_IDLE && f_valid && day_flag_r && room6) |=> do_time) else $error("time record missed");
   // Month word lies in its range
   a_month_word: assert property (@(posedge CLK) disable iff (RESET)
      (do_time && idx_r == 3'd2) |-> (wr_data >= 10'd1 && wr_data <= 10'd12)) else $error("bad month");
   // Leap year February reaches its 29th
   a_leap_feb: assert property (@(posedge CLK) disable iff (RESET)
      (day_wrap && month_r == 4'd2 && day_r == 5'd28 && year_r[1:0] == 2'b00) |=> (month_r == 4'd2 && day_r == 5'd29))
      else $error("leap day skipped");
   // Empty store delivers nothing
   a_read_empty: assert property (@(posedge CLK) disable iff (RESET)
      (count_r == 17'd0) |=> !rd_valid_r) else $error("read from empty");
endmodule
`default_nettype wire

// ### logic/word_store_params.svh
// Constants for the word storage unit
`ifndef WORD_STORE_PARAMS_SVH
`define WORD_STORE_PARAMS_SVH
`define WS_WORD_W        10
`define WS_CAPACITY      17'd65520
`define WS_REC_WORDS     3'd6
`define WS_TIME_HEADER   10'h007
`define WS_RESET_YEAR    7'd0
`define WS_RESET_MONTH   4'd1
`define WS_RESET_DAY     5'd1
`define WS_CLK_HZ        64'd100000000
`define WS_MINUTE_S      64'd60
`define WS_MINUTE_CYC    (`WS_CLK_HZ * `WS_MINUTE_S)
`define WS_FIFO_DEPTH    16
`endif

// ### logic/word_store_pkg.sv
// Types for the word storage unit
`default_nettype none
package word_store_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_TIME, ST_MEAS} store_state_e;
   typedef logic [9:0] word_t;
endpackage
`default_nettype wire

// ### logic/word_fifo.sv
// Parameterised valid/ready FIFO
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];      // Storage array
   logic [AW-1:0]    wr_ptr_r;         // Write pointer
   logic [AW-1:0]    rd_ptr_r;         // Read pointer
   logic [AW:0]      count_r;          // Fill level
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];
   // Pointer and level update
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Data write
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr_r] <= in_data;
   end
endmodule
`default_nettype wire

// ### test/word_sender.sv
// Behavioural sender of decoded measurement words
`default_nettype none
module word_sender import word_store_pkg::*; (
   input  wire logic CLK,
   input  wire logic IN_READY,
   output var logic  IN_VALID,
   output var word_t IN_WORD,
   output var logic  IN_REC_END
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines at time zero
   initial begin
      IN_VALID   = 1'b0;
      IN_WORD    = '0;
      IN_REC_END = 1'b0;
   end

   // Rotor speed word: the switch gives two pulses per revolution
   function automatic word_t revs_word(input int pulses);
      return word_t'(pulses / 2);
   endfunction

   // Send n words from base; a sync pulse after every sixth when rec is set
   task automatic send_burst(input word_t base, input int n, input bit rec);
      int i;
      int w;
      for (i = 0; i < n; i++) begin
         IN_VALID <= 1'b1;
         IN_WORD  <= base + word_t'(i);
         w = 0;
         do begin @(posedge CLK); w++; end while (IN_READY !== 1'b1 && w < 2000);
         if (rec && (i % 6 == 5)) begin
            IN_VALID   <= 1'b0;
            IN_WORD    <= ~(base + word_t'(i));
            IN_REC_END <= 1'b1;
            @(posedge CLK);
            IN_REC_END <= 1'b0;
         end
      end
      IN_VALID <= 1'b0;
      IN_WORD  <= ~(base + word_t'(n - 1));
   endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the word storage unit
`default_nettype none
module tb_top import word_store_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_CYC = 10;  // Shortened minute
   logic        clk, reset, rd_req, in_valid, in_ready, in_rec_end, rd_valid, full;
   word_t       in_word, rd_word;
   logic [16:0] word_count;
   int          n_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;
   word_t       got[$];

   word_storage_unit #(.MINUTE_CYC(MIN_CYC), .DEPTH(65536)) word_storage_unit_inst (
      .CLK(clk), .RESET(reset), .IN_VALID(in_valid), .IN_READY(in_ready), .IN_WORD(in_word),
      .IN_REC_END(in_rec_end), .RD_REQ(rd_req), .RD_VALID(rd_valid), .RD_WORD(rd_word),
      .WORD_COUNT(word_count), .FULL(full));
   word_sender word_sender_inst (.CLK(clk), .IN_READY(in_ready), .IN_VALID(in_valid),
      .IN_WORD(in_word), .IN_REC_END(in_rec_end));

   // Clock and cycles since reset
   initial begin clk = 1'b0; forever #5 clk = ~clk; end
   always @(posedge clk) cyc <= reset ? 0 : cyc + 1;

   // Compare one value
   task automatic check(input logic [16:0] g, input logic [16:0] e, input string m);
      comparisons++;
      if (g !== e) begin n_errors++; $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, e); end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Read n words holding the request, then confirm nothing more comes
   task automatic read_all(input int n);
      int k;
      logic [16:0] start;
      start = word_count;
      got.delete();
      rd_req <= 1'b1;
      for (k = 0; k < 4 * n + 10 && got.size() < n; k++) begin
         @(posedge clk); #1;
         if (rd_valid === 1'b1) begin
            got.push_back(rd_word);
            check(word_count, start - 17'(got.size()), "count after read");
         end
      end
      check(17'(got.size()), 17'(n), "words read");
      repeat (3) begin @(posedge clk); #1; check({16'h0, rd_valid}, 17'h0, "read when empty"); end
      @(posedge clk);
      rd_req <= 1'b0;
   endtask

   // Judge the six words of a time record
   task automatic check_time(input int day, input int t0);
      int m;
      m = (t0 / MIN_CYC) % 1440;
      check(17'(got[0]), 17'h7, "header");
      check(17'(got[1]), 17'h0, "year");
      check(17'(got[2]), 17'h1, "month");
      check(17'(got[3]), 17'(day), "day");
      check(17'(got[4]), 17'(m / 60), "hour");
      comparisons++;
      if ((got[5] >= m % 60 && got[5] <= m % 60 + 2) !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: minute %0d", $time, got[5]);
      end
   endtask

   task automatic test_power_on_and_read();
      int t0;
      int i;
      t0 = cyc;
      word_sender_inst.send_burst(10'h155, 6, 1'b1);
      wait_cyc(20);
      check(word_count, 17'd12, "count after first record");
      word_sender_inst.send_burst(word_sender_inst.revs_word(694), 6, 1'b1);
      wait_cyc(20);
      check(word_count, 17'd18, "count after second record");
      read_all(18);
      check_time(1, t0);
      for (i = 0; i < 12; i++) check(17'(got[6 + i]), 17'(10'h155 + i), "stored word");
      $display("test power-on and readout done");
   endtask

   task automatic test_midnight();
      int t0;
      while (cyc < 1440 * MIN_CYC + 20) @(posedge clk);
      t0 = cyc;
      word_sender_inst.send_burst(10'h3f0, 6, 1'b1);
      wait_cyc(20);
      check(word_count, 17'd12, "count after midnight record");
      read_all(12);
      check_time(2, t0);
      $display("test midnight done");
   endtask

   task automatic test_full();
      word_sender_inst.send_burst(10'h000, 65530, 1'b0);
      wait_cyc(20);
      check(word_count, 17'd65520, "count at capacity");
      check({16'h0, full}, 17'h1, "full flag");
      word_sender_inst.send_burst(10'h2aa, 6, 1'b1);
      wait_cyc(20);
      check(word_count, 17'd65520, "count when full");
      $display("test full done");
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Watchdog sized above the fill and midnight waits
   initial begin
      repeat (95000) @(posedge clk);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      rd_req = 1'b0;
      reset  = 1'b1;
      wait_cyc(8);
      reset <= 1'b0;
      wait_cyc(2);
      test_power_on_and_read();
      test_midnight();
      test_full();
      wrap_up();
   end
endmodule
`default_nettype wire
